// >>> inc/dtt_pkg.sv
/*
  Constants for the dynamic termination timing block: termination select
  codes, latency offsets, history depth and asynchronous-mode timing.
  Assumes a 125 MHz core clock; all counts are in core clock cycles.
*/
package dtt_pkg;

  // ---------------------------------------------------------------
  // Termination select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_PARK  = 2'h0;
  localparam logic [1:0] SEL_NOM   = 2'h1;
  localparam logic [1:0] SEL_WRITE = 2'h2;
  localparam logic [1:0] SEL_TRANS = 2'h3;

  // ---------------------------------------------------------------
  // Latency offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] ONSET_SUB_PRE1 = 7'h02;
  localparam logic [6:0] ONSET_SUB_PRE2 = 7'h03;
  // Release offsets above onset, indexed {preamble_2clk, write_crc_en}.
  localparam logic [6:0] REL4_P1_C0 = 7'h04;
  localparam logic [6:0] REL4_P1_C1 = 7'h07;
  localparam logic [6:0] REL4_P2_C0 = 7'h05;
  localparam logic [6:0] REL4_P2_C1 = 7'h08;
  localparam logic [6:0] REL8_P1_C0 = 7'h06;
  localparam logic [6:0] REL8_P1_C1 = 7'h07;
  localparam logic [6:0] REL8_P2_C0 = 7'h07;
  localparam logic [6:0] REL8_P2_C1 = 7'h08;

  // History depth covers onset plus release offset up to 65 cycles, not the longest write latency the inputs allow.
  localparam int HIST_DEPTH = 64;

  // ---------------------------------------------------------------
  // Asynchronous mode timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int ASYNC_ON_MIN_NS  = 2;
  localparam int ASYNC_ON_MAX_NS  = 16;
  localparam int ASYNC_OFF_MIN_NS = 2;
  localparam int ASYNC_OFF_MAX_NS = 16;
  localparam int ON_MIN_RAW  = (ASYNC_ON_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ON_MAX_RAW  = ASYNC_ON_MAX_NS / CLK_PERIOD_NS;
  localparam int OFF_MIN_RAW = (ASYNC_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_MAX_RAW = ASYNC_OFF_MAX_NS / CLK_PERIOD_NS;
  localparam logic [3:0] ON_MIN_CYC  = 4'(ON_MIN_RAW < 1 ? 1 : ON_MIN_RAW);
  localparam logic [3:0] ON_MAX_CYC  = 4'(ON_MAX_RAW < 1 ? 1 : ON_MAX_RAW);
  localparam logic [3:0] OFF_MIN_CYC = 4'(OFF_MIN_RAW < 1 ? 1 : OFF_MIN_RAW);
  localparam logic [3:0] OFF_MAX_CYC = 4'(OFF_MAX_RAW < 1 ? 1 : OFF_MAX_RAW);
  localparam logic [3:0] ASYNC_CNT_SAT = 4'hf;

endpackage

// >>> rtl/dtt_sync2.sv
/*
  Two-flop level synchroniser for the termination control pin.
  Assumes the input is asynchronous to core_clk.
*/
`timescale 1ns/100ps
module dtt_sync2 (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// >>> rtl/dtt_core.sv
/*
  Termination sequencer: selects parked, nominal or write termination
  from the write command stream, the termination control pin and the
  mode settings in clocked mode, and parked, transition or nominal from
  the pin alone in asynchronous (delay-locked loop off) mode.
  Assumes write_cmd and all mode inputs come from core_clk logic and that
  mode inputs are changed only while no write is in flight.
*/
`timescale 1ns/100ps
module dtt_core (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       write_cmd,
  input  wire logic       burst_chop_four,
  input  wire logic [4:0] column_write_latency,
  input  wire logic [4:0] additive_latency,
  input  wire logic [3:0] parity_latency,
  input  wire logic       preamble_2clk,
  input  wire logic       write_crc_en,
  input  wire logic       dll_off,
  input  wire logic       dyn_term_en_a,
  input  wire logic       dyn_term_en_b,
  input  wire logic [2:0] write_termination,
  input  wire logic       termination_control_pin,
  output logic [1:0]      term_sel_r,
  output logic [6:0]      write_latency_r
);
  import dtt_pkg::*;

  // ---------------------------------------------------------------
  // Latency arithmetic
  // ---------------------------------------------------------------
  logic [6:0] write_latency;
  logic [6:0] onset_lat;
  logic [6:0] rel4_off;
  logic [6:0] rel8_off;
  logic       dyn_ok;
  logic       pin_s;

  assign write_latency = 7'(column_write_latency) + 7'(additive_latency)
                       + 7'(parity_latency);
  assign onset_lat = write_latency - (preamble_2clk ? ONSET_SUB_PRE2 : ONSET_SUB_PRE1);

  always_comb begin
    case ({preamble_2clk, write_crc_en})
      2'h0:    rel4_off = REL4_P1_C0;
      2'h1:    rel4_off = REL4_P1_C1;
      2'h2:    rel4_off = REL4_P2_C0;
      default: rel4_off = REL4_P2_C1;
    endcase
    case ({preamble_2clk, write_crc_en})
      2'h0:    rel8_off = REL8_P1_C0;
      2'h1:    rel8_off = REL8_P1_C1;
      2'h2:    rel8_off = REL8_P2_C0;
      default: rel8_off = REL8_P2_C1;
    endcase
  end

  // Disabled by a zero write value even if an enable bit is set.
  assign dyn_ok = (dyn_term_en_a | dyn_term_en_b) & (write_termination != 3'h0)
                & ~dll_off;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      write_latency_r <= 7'h00;
    end else begin
      write_latency_r <= write_latency;
    end
  end

  // ---------------------------------------------------------------
  // Pin synchroniser and histories
  // ---------------------------------------------------------------
  dtt_sync2 u_pin_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (termination_control_pin),
    .sync_out (pin_s)
  );

  logic [HIST_DEPTH-1:0] wr_hist_r;
  logic [HIST_DEPTH-1:0] chop_hist_r;
  logic [HIST_DEPTH-1:0] pin_hist_r;
  logic [HIST_DEPTH-1:0] wr_act;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wr_hist_r   <= '0;
      chop_hist_r <= '0;
      pin_hist_r  <= '0;
    end else begin
      wr_hist_r   <= {wr_hist_r[HIST_DEPTH-2:0], write_cmd};
      chop_hist_r <= {chop_hist_r[HIST_DEPTH-2:0], burst_chop_four};
      pin_hist_r  <= {pin_hist_r[HIST_DEPTH-2:0], pin_s};
    end
  end

  // Entry j holds a write whose age becomes j+1 at the coming edge.
  // Overlapping writes simply widen the window.
  genvar j;
  generate
    for (j = 0; j < HIST_DEPTH; j++) begin : g_age
      localparam logic [6:0] AGE = 7'(j + 1);
      assign wr_act[j] = wr_hist_r[j] && (AGE >= onset_lat)
        && (AGE < onset_lat + (chop_hist_r[j] ? rel4_off : rel8_off));
    end
  endgenerate

  // ---------------------------------------------------------------
  // Asynchronous mode timer
  // ---------------------------------------------------------------
  logic       pin_last_r;
  logic [3:0] async_cnt_r;
  logic [3:0] async_cnt_nxt;
  logic       pin_change;

  assign pin_change    = pin_s != pin_last_r;
  assign async_cnt_nxt = pin_change ? 4'h1 :
                         (async_cnt_r == ASYNC_CNT_SAT) ? async_cnt_r : async_cnt_r + 4'h1;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_last_r  <= 1'b0;
      async_cnt_r <= ASYNC_CNT_SAT;
    end else begin
      pin_last_r  <= pin_s;
      async_cnt_r <= async_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Termination select
  // ---------------------------------------------------------------
  logic [1:0] sel_nxt;
  logic       nom_req;

  // The pin tap shares the onset offset; on and off latencies are equal.
  assign nom_req = (onset_lat != 7'h00) && pin_hist_r[6'(onset_lat - 7'h01)];

  always_comb begin
    sel_nxt = SEL_PARK;
    if (dll_off) begin
      // The synchronised pin is used directly, no latency added.
      if (pin_s) begin
        if (async_cnt_nxt < ON_MIN_CYC) begin
          sel_nxt = SEL_PARK;
        end else if (async_cnt_nxt < ON_MAX_CYC) begin
          sel_nxt = SEL_TRANS;
        end else begin
          sel_nxt = SEL_NOM;
        end
      end else begin
        if (async_cnt_nxt < OFF_MIN_CYC) begin
          sel_nxt = SEL_NOM;
        end else if (async_cnt_nxt < OFF_MAX_CYC) begin
          sel_nxt = SEL_TRANS;
        end else begin
          sel_nxt = SEL_PARK;
        end
      end
    end else if (dyn_ok && (wr_act != '0)) begin
      sel_nxt = SEL_WRITE;
    end else if (nom_req) begin
      sel_nxt = SEL_NOM;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      term_sel_r <= SEL_PARK;
    end else begin
      term_sel_r <= sel_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [6:0] since_wr_r;
  logic       last_chop_r;
  localparam int ON_MAX_I  = int'(ON_MAX_CYC);
  localparam int OFF_MAX_I = int'(OFF_MAX_CYC);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      since_wr_r  <= 7'h7f;
      last_chop_r <= 1'b0;
    end else if (write_cmd) begin
      since_wr_r  <= 7'h01;
      last_chop_r <= burst_chop_four;
    end else if (since_wr_r != 7'h7f) begin
      since_wr_r  <= since_wr_r + 7'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_wr_onset: assert property (
    (since_wr_r == onset_lat) && dyn_ok && !dll_off |=> term_sel_r == SEL_WRITE)
    else $error("write termination not selected at onset");
  chk_chop_release: assert property (
    (since_wr_r == onset_lat + rel4_off) && last_chop_r && $onehot(wr_hist_r)
    |=> term_sel_r != SEL_WRITE)
    else $error("chop-four write termination held past release");
  chk_burst8_release: assert property (
    (since_wr_r == onset_lat + rel8_off) && !last_chop_r && $past(dyn_ok)
    && !dll_off |-> term_sel_r == SEL_WRITE
    ##1 (term_sel_r != SEL_WRITE || !$onehot(wr_hist_r)))
    else $error("burst-eight write termination window wrong");
  chk_sync_no_trans: assert property (
    !dll_off |=> term_sel_r != SEL_TRANS)
    else $error("transition state outside asynchronous mode");
  chk_async_nodelay: assert property (
    (dll_off && pin_s) [*4] |=> term_sel_r == SEL_NOM)
    else $error("asynchronous request delayed by latency");
  chk_async_turn_on: assert property (
    dll_off && pin_change && pin_s ##1 (dll_off && pin_s) [*2]
    |-> ##[0:ON_MAX_I] term_sel_r == SEL_NOM)
    else $error("asynchronous turn-on too slow");
  chk_async_turn_off: assert property (
    dll_off && pin_change && !pin_s ##1 (dll_off && !pin_s) [*2]
    |-> ##[0:OFF_MAX_I] term_sel_r == SEL_PARK)
    else $error("asynchronous turn-off too slow");
  chk_dyn_disabled: assert property (
    !dyn_ok |=> term_sel_r != SEL_WRITE)
    else $error("write termination while dynamic switching disabled");
  chk_park_when_idle: assert property (
    !dll_off && (pin_hist_r == '0) && (wr_hist_r == '0) |=> term_sel_r == SEL_PARK)
    else $error("termination not parked while idle");
  chk_no_dyn_dll_off: assert property (
    dll_off |=> term_sel_r != SEL_WRITE)
    else $error("write termination with loop off");

  cov_chop_write: cover property (write_cmd && burst_chop_four && dyn_ok
    ##[1:60] term_sel_r == SEL_WRITE);
  cov_burst8_write: cover property (write_cmd && !burst_chop_four && dyn_ok
    ##[1:60] term_sel_r == SEL_WRITE);
  cov_async_on: cover property (dll_off && term_sel_r == SEL_TRANS ##1 term_sel_r == SEL_NOM);
  cov_overlap_nom: cover property (term_sel_r == SEL_NOM ##1 term_sel_r == SEL_WRITE
    ##[1:16] term_sel_r == SEL_NOM);

endmodule

// >>> dv/dtt_ctrl_model.sv
/*
  Controller-side partner model: issues write commands and drives the
  termination control pin of the termination sequencer.
  Assumes the bench calls its tasks from one process, one at a time.
*/
`timescale 1ns/100ps
module dtt_ctrl_model (
  input  wire logic core_clk,
  output logic      write_cmd,
  output logic      burst_chop_four,
  output logic      termination_control_pin
);
  initial begin
    write_cmd               = 1'b0;
    burst_chop_four         = 1'b0;
    termination_control_pin = 1'b0;
  end

  // ---------------------------------------------------------------
  // Command and pin drivers
  // ---------------------------------------------------------------
  // The chop flag only means something beside the write pulse, so it is
  // inverted afterwards to catch a design that samples it too late.
  task automatic send_write(input logic chop);
    @(posedge core_clk);
    #1;
    write_cmd       = 1'b1;
    burst_chop_four = chop;
    @(posedge core_clk);
    #1;
    write_cmd       = 1'b0;
    burst_chop_four = ~chop;
  endtask

  task automatic drive_pin(input logic lvl);
    @(posedge core_clk);
    #1;
    termination_control_pin = lvl;
  endtask
endmodule

// >>> dv/testbench.sv
/*
  Self-checking bench for the termination sequencer.
  Assumes the controller model in dtt_ctrl_model and the package constants.
*/
`timescale 1ns/100ps
module testbench;
  import dtt_pkg::*;
  logic       core_clk = 1'b0;
  logic       sys_rst  = 1'b1;
  logic       write_cmd;
  logic       burst_chop_four;
  logic       termination_control_pin;
  logic [4:0] cwl;
  logic [4:0] al;
  logic [3:0] pl;
  logic       preamble_2clk;
  logic       write_crc_en;
  logic       dll_off;
  logic       en_a;
  logic       en_b;
  logic [2:0] wr_term;
  logic [1:0] term_sel_r;
  logic [6:0] write_latency_r;
  int         bad_count = 0;
  int         n_tests   = 0;
  int         k;

  always #4 core_clk = ~core_clk;

  dtt_ctrl_model ctrl (.core_clk(core_clk), .write_cmd(write_cmd),
    .burst_chop_four(burst_chop_four), .termination_control_pin(termination_control_pin));

  dtt_core uut (.core_clk(core_clk), .sys_rst(sys_rst), .write_cmd(write_cmd),
    .burst_chop_four(burst_chop_four), .column_write_latency(cwl), .additive_latency(al),
    .parity_latency(pl), .preamble_2clk(preamble_2clk), .write_crc_en(write_crc_en),
    .dll_off(dll_off), .dyn_term_en_a(en_a), .dyn_term_en_b(en_b),
    .write_termination(wr_term), .termination_control_pin(termination_control_pin),
    .term_sel_r(term_sel_r), .write_latency_r(write_latency_r));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input bit ok, input string msg);
    n_tests++;
    if (!ok) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Counts edges until the select shows v; a bound cuts a hang short.
  task automatic wait_sel(input logic [1:0] v, output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1;
      cnt++;
    end while (term_sel_r !== v && cnt < 90);
    if (term_sel_r !== v) begin
      check(1'b0, "select wait timed out");
      close_out();
    end
  endtask

  task automatic expect_no_write(input string msg);
    bit seen;
    seen = 1'b0;
    ctrl.send_write(1'b0);
    repeat (40) begin
      @(posedge core_clk);
      #1;
      if (term_sel_r !== SEL_PARK) seen = 1'b1;
    end
    check(!seen, msg);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_write_table();
    int rel [8] = '{4, 7, 5, 8, 6, 7, 7, 8};
    int onset;
    for (int i = 0; i < 8; i++) begin
      preamble_2clk = i[1];
      write_crc_en  = i[0];
      onset = 12 - (i[1] ? 3 : 2);
      ctrl.send_write(~i[2]);
      wait_sel(SEL_WRITE, k);
      check(k == onset, "write onset");
      wait_sel(SEL_PARK, k);
      check(k == rel[i], "write release");
      // Mode settings may only move once the last write has aged out.
      repeat (8) @(posedge core_clk);
      #1;
    end
    preamble_2clk = 1'b0;
    write_crc_en  = 1'b0;
    en_a          = 1'b0;
    en_b          = 1'b1;
    ctrl.send_write(1'b1);
    wait_sel(SEL_WRITE, k);
    check(k == 10, "second enable bit");
    wait_sel(SEL_PARK, k);
    $display("test write_table done");
  endtask

  task automatic test_disable();
    wr_term = 3'h0;
    expect_no_write("write value zero");
    wr_term = 3'h2;
    en_b    = 1'b0;
    expect_no_write("both enables low");
    en_a    = 1'b1;
    dll_off = 1'b1;
    expect_no_write("loop off");
    dll_off = 1'b0;
    $display("test disable done");
  endtask

  task automatic test_sync_pin();
    // Two synchroniser stages and the history stage precede the onset count.
    ctrl.drive_pin(1'b1);
    wait_sel(SEL_NOM, k);
    check(k == 13, "nominal on latency");
    ctrl.send_write(1'b1);
    wait_sel(SEL_WRITE, k);
    check(k == 10, "write over nominal");
    wait_sel(SEL_NOM, k);
    check(k == 4, "back to nominal");
    ctrl.drive_pin(1'b0);
    wait_sel(SEL_PARK, k);
    check(k == 13, "parked off latency");
    $display("test sync_pin done");
  endtask

  // A latency with no additive or parity part must move the onset with it.
  task automatic test_latency_sum();
    cwl = 5'h0b;
    al  = 5'h00;
    pl  = 4'h0;
    @(posedge core_clk);
    #1;
    check(write_latency_r === 7'h0b, "write latency sum, column only");
    ctrl.send_write(1'b0);
    wait_sel(SEL_WRITE, k);
    check(k == 9, "onset follows write latency");
    wait_sel(SEL_PARK, k);
    check(k == 6, "burst-eight release, short latency");
    repeat (4) @(posedge core_clk);
    #1;
    cwl = 5'h09;
    al  = 5'h02;
    pl  = 4'h1;
    $display("test latency_sum done");
  endtask

  // Additive and parity latency stay set here, so a prompt answer proves
  // they are left out of the asynchronous path.
  task automatic test_async_pin();
    dll_off = 1'b1;
    ctrl.drive_pin(1'b1);
    wait_sel(SEL_TRANS, k);
    check(k == 2 + int'(ON_MIN_CYC), "turn-on start");
    wait_sel(SEL_NOM, k);
    check(k == int'(ON_MAX_CYC) - int'(ON_MIN_CYC), "turn-on end");
    ctrl.drive_pin(1'b0);
    wait_sel(SEL_TRANS, k);
    check(k == 2 + int'(OFF_MIN_CYC), "turn-off start");
    wait_sel(SEL_PARK, k);
    check(k == int'(OFF_MAX_CYC) - int'(OFF_MIN_CYC), "turn-off end");
    dll_off = 1'b0;
    $display("test async_pin done");
  endtask

  initial begin
    cwl           = 5'h09;
    al            = 5'h02;
    pl            = 4'h1;
    preamble_2clk = 1'b0;
    write_crc_en  = 1'b0;
    dll_off       = 1'b0;
    en_a          = 1'b1;
    en_b          = 1'b0;
    wr_term       = 3'h2;
    repeat (16) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    @(posedge core_clk);
    #1;
    check(write_latency_r === 7'h0c, "write latency sum");
    check(term_sel_r === SEL_PARK, "parked after reset");
    test_write_table();
    test_disable();
    test_sync_pin();
    test_latency_sum();
    test_async_pin();
    close_out();
  end
endmodule
